// [rtl/smsp_pkg.sv]
// constants and types shared by the spi serial port design
package smsp_pkg;
   // system clock period; the master bit rates are divisions of it
   localparam int unsigned CLK_PERIOD_NS = 10;

   // data width and receive buffering depth
   localparam int unsigned DATA_W = 8;
   localparam int unsigned RX_FIFO_DEPTH = 2;
   localparam logic [7:0] DATA_RST = 8'h00;

   // field positions in the port_control_one input (register bits 5:0)
   localparam int unsigned CTL_MODE_LSB = 0;
   localparam int unsigned CTL_CKP_BIT = 4;
   localparam int unsigned CTL_EN_BIT = 5;

   // field positions in the port_status_reg input (register bits 7:6)
   localparam int unsigned STS_CKE_BIT = 0;
   localparam int unsigned STS_SMP_BIT = 1;

   // role and bit rate codes of the mode field
   localparam logic [3:0] MODE_M_DIV4 = 4'h0;
   localparam logic [3:0] MODE_M_DIV16 = 4'h1;
   localparam logic [3:0] MODE_M_DIV64 = 4'h2;
   localparam logic [3:0] MODE_M_TMR2 = 4'h3;
   localparam logic [3:0] MODE_S_SSEN = 4'h4;
   localparam logic [3:0] MODE_S_SSDIS = 4'h5;
   localparam logic [3:0] MODE_M_RELOAD = 4'hA;

   // half bit periods in system clocks: bit rate fosc/4, fosc/16, fosc/64
   localparam logic [9:0] HALF_DIV4 = 10'h002;
   localparam logic [9:0] HALF_DIV16 = 10'h008;
   localparam logic [9:0] HALF_DIV64 = 10'h020;

   // half periods per byte and index of the last bit in a byte
   localparam logic [4:0] LAST_HALF = 5'h10;
   localparam logic [3:0] LAST_BIT = 4'h7;

   typedef enum logic [1:0] {
      SMSP_M_IDLE = 2'b00,
      SMSP_M_WAIT = 2'b01,
      SMSP_M_RUN = 2'b10
   } smsp_mstate_t;
endpackage

// [rtl/smsp_fifo.sv]
// small receive buffer with valid and ready on both sides
`timescale 1ns/1ns
module smsp_fifo #(
   parameter int unsigned WIDTH = 8,
   parameter int unsigned DEPTH = 2
) (
   input wire logic clock_i,
   input wire logic nrst_i,
   input wire logic in_valid_i,
   output logic in_ready_o,
   input wire logic [WIDTH-1:0] in_data_i,
   output logic out_valid_o,
   input wire logic out_ready_i,
   output logic [WIDTH-1:0] out_data_o
);
   localparam int unsigned AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
   localparam logic [AW:0] FULL_CNT = (AW + 1)'(DEPTH);
   localparam logic [AW-1:0] LAST_PTR = AW'(DEPTH - 1);

   logic [WIDTH-1:0] mem_q [DEPTH];
   logic [AW-1:0] wr_ptr_q;
   logic [AW-1:0] rd_ptr_q;
   logic [AW:0] cnt_q;
   logic push;
   logic pop;

   // honest flags straight from the occupancy count
   assign in_ready_o = (cnt_q != FULL_CNT);
   assign out_valid_o = (cnt_q != '0);
   assign out_data_o = mem_q[rd_ptr_q];
   assign push = in_valid_i && in_ready_o;
   assign pop = out_valid_o && out_ready_i;

   // storage is not reset; only entries counted as full are ever read
   always_ff @(posedge clock_i) begin
      if (push) begin
         mem_q[wr_ptr_q] <= in_data_i;
      end
   end

   // pointers and occupancy
   always_ff @(posedge clock_i) begin
      if (!nrst_i) begin
         wr_ptr_q <= '0;
         rd_ptr_q <= '0;
         cnt_q <= '0;
      end else begin
         if (push) begin
            wr_ptr_q <= (wr_ptr_q == LAST_PTR) ? '0 : wr_ptr_q + AW'(1);
         end
         if (pop) begin
            rd_ptr_q <= (rd_ptr_q == LAST_PTR) ? '0 : rd_ptr_q + AW'(1);
         end
         if (push && !pop) begin
            cnt_q <= cnt_q + (AW + 1)'(1);
         end else if (pop && !push) begin
            cnt_q <= cnt_q - (AW + 1)'(1);
         end
      end
   end
endmodule // smsp_fifo

// [rtl/smsp_port.sv]
// spi master and slave port with receive buffering and status flags
`timescale 1ns/1ns
// Overview of operation
// R1: role, polarity, edge, phase, rate and select come from control and status bits
// R2: master drives the serial clock; slave takes it from the far party
// R3: software reconfigures only while the port enable bit is clear
// R4: software sets pin directions so each pin serves its port function
// R5: bytes shift out and in most significant bit first
// R6: a received byte goes to the data buffer, setting full and interrupt flags
// R7: received bytes are double buffered so reception continues before a read
// R8: a buffer write during a transfer is dropped and sets write collision
// R9: software clears write collision before further writes are taken
// R10: reading the data buffer clears the buffer full flag
// R11: the shift register is reached only through the data buffer
// R12: the master owns the serial clock and may start at any time; here a write waits in SMSP_M_WAIT until the receive buffer has room
// R13: in master role a buffer write starts a one byte full duplex transfer
// R14: with output disabled the master still receives bytes with normal flags
// R15: clock polarity sets the idle level; clock edge bit picks output edge
// R16: master rate is fosc/4, /16, /64, timer2/2 or fosc/(4*(reload+1))
// R17: with the clock edge bit set, output data is valid before the first edge
// R18: sample phase picks input sampling at middle or end of output time
// R19: rate applies in master role only; slave select in slave role only
// R20: a slave shifts on far master edges, only while select is low if used
module smsp_port (
   input wire logic clock_i,
   input wire logic nrst_i,
   input wire logic [5:0] port_control_one_i,
   input wire logic [1:0] port_status_reg_i,
   input wire logic [7:0] rate_reload_value_i,
   input wire logic timer2_tick_i,
   input wire logic buf_wr_i,
   input wire logic [7:0] buf_wdata_i,
   input wire logic buf_rd_i,
   input wire logic int_clr_i,
   input wire logic write_collision_flag_clr_i,
   input wire logic ovf_clr_i,
   output logic [7:0] data_buffer_o,
   output logic buffer_full_flag_o,
   output logic port_interrupt_flag_o,
   output logic write_collision_flag_o,
   output logic rx_overflow_o,
   output logic busy_o,
   input wire logic sck_i,
   output logic sck_o,
   output logic sck_oe_n_o,
   input wire logic sdi_i,
   output logic sdo_o,
   output logic sdo_oe_n_o,
   input wire logic ss_n_i
);
   // configuration decode
   logic en;
   logic cpol;
   logic cke;
   logic sample_phase_bit;
   logic [3:0] mode;
   logic is_master;
   logic is_slave;
   logic ss_used;
   // pin synchronisers
   logic sck_s1_q, sck_s2_q, sck_s3_q;
   logic sdi_s1_q, sdi_s2_q;
   logic ss_s1_q, ss_s2_q;
   // master sequencing
   smsp_pkg::smsp_mstate_t mstate_q;
   logic [9:0] div_q;
   logic [9:0] half_len;
   logic tick;
   logic run_tick;
   logic [4:0] t_q;
   logic [4:0] t_n;
   logic [4:0] u_n;
   logic mid_pt;
   logic end_pt;
   logic m_sample;
   logic m_change;
   logic m_done;
   // slave sequencing
   logic s_active;
   logic s_edge;
   logic s_to_active;
   logic s_sample;
   logic s_change;
   logic s_last;
   // shift path and buffering
   logic [7:0] shift_register_q;
   logic [7:0] rx_shift_q;
   logic [7:0] rx_next;
   logic [3:0] rx_cnt_q;
   logic busy;
   logic accept_wr;
   logic fifo_in_valid;
   logic fifo_in_ready;
   logic [7:0] fifo_in_data;
   logic fifo_out_valid;
   logic fifo_out_ready;
   logic [7:0] fifo_out_data;
   logic load_buf;
   // output registers
   logic [7:0] data_buffer_q;
   logic bf_q, int_q, write_collision_flag_q, ovf_q, busy_q;
   logic sck_q, sck_oe_n_q, sdo_q, sdo_oe_n_q;

   // field decode; rate codes mean master, select codes mean slave
   assign en = port_control_one_i[smsp_pkg::CTL_EN_BIT]; // R1
   assign cpol = port_control_one_i[smsp_pkg::CTL_CKP_BIT];
   assign mode = port_control_one_i[smsp_pkg::CTL_MODE_LSB +: 4];
   assign cke = port_status_reg_i[smsp_pkg::STS_CKE_BIT];
   assign sample_phase_bit = port_status_reg_i[smsp_pkg::STS_SMP_BIT];
   assign is_master = en && ((mode == smsp_pkg::MODE_M_DIV4)
      || (mode == smsp_pkg::MODE_M_DIV16) || (mode == smsp_pkg::MODE_M_DIV64)
      || (mode == smsp_pkg::MODE_M_TMR2) || (mode == smsp_pkg::MODE_M_RELOAD));
   assign is_slave = en && ((mode == smsp_pkg::MODE_S_SSEN)
      || (mode == smsp_pkg::MODE_S_SSDIS));
   assign ss_used = (mode == smsp_pkg::MODE_S_SSEN); // R19

   // two flops on every pin input before any logic looks at it
   always_ff @(posedge clock_i) begin
      if (!nrst_i) begin
         sck_s1_q <= cpol; // idle level, so no false edge right after reset
         sck_s2_q <= cpol;
         sck_s3_q <= cpol;
         sdi_s1_q <= 1'b0;
         sdi_s2_q <= 1'b0;
         ss_s1_q <= 1'b1;
         ss_s2_q <= 1'b1;
      end else begin
         sck_s1_q <= sck_i;
         sck_s2_q <= sck_s1_q;
         sck_s3_q <= sck_s2_q;
         sdi_s1_q <= sdi_i;
         sdi_s2_q <= sdi_s1_q;
         ss_s1_q <= ss_n_i;
         ss_s2_q <= ss_s1_q;
      end
   end

   // half bit length for the divider modes; only used in master role
   always_comb begin
      unique case (mode)
         smsp_pkg::MODE_M_DIV16: half_len = smsp_pkg::HALF_DIV16; // R16
         smsp_pkg::MODE_M_DIV64: half_len = smsp_pkg::HALF_DIV64;
         smsp_pkg::MODE_M_RELOAD: half_len = {1'b0, rate_reload_value_i, 1'b0} + 10'h002;
         default: half_len = smsp_pkg::HALF_DIV4;
      endcase
   end
   assign tick = (mode == smsp_pkg::MODE_M_TMR2) ? timer2_tick_i : (div_q == half_len - 10'h001);
   assign run_tick = is_master && (mstate_q == smsp_pkg::SMSP_M_RUN) && tick; // R19

   // phase tracking: u counts half periods of the data output time
   always_comb begin
      t_n = t_q + 5'h01;
      u_n = cke ? t_n : (t_n - 5'h01);
      mid_pt = u_n[0];
      end_pt = !u_n[0] && (u_n != 5'h00);
      m_sample = run_tick && (sample_phase_bit ? end_pt : mid_pt); // R18
      m_change = run_tick && end_pt && (u_n < smsp_pkg::LAST_HALF); // R15
      m_done = run_tick && (u_n == smsp_pkg::LAST_HALF);
   end

   // slave edge decode on the synchronised clock, gated by select
   assign s_active = is_slave && (!ss_used || !ss_s2_q); // R20
   assign s_edge = s_active && (sck_s2_q != sck_s3_q);
   assign s_to_active = s_edge && (sck_s2_q != cpol);
   assign s_sample = cke ? s_to_active : (s_edge && !s_to_active);
   assign s_change = (cke ? (s_edge && !s_to_active) : s_to_active) && (rx_cnt_q != 4'h0);
   assign s_last = s_sample && (rx_cnt_q == smsp_pkg::LAST_BIT);

   // collision and acceptance of software writes
   assign busy = (is_master && (mstate_q != smsp_pkg::SMSP_M_IDLE))
      || (is_slave && (rx_cnt_q != 4'h0));
   assign accept_wr = buf_wr_i && en && !busy && !write_collision_flag_q; // R9

   // master state: a write starts the byte, waiting only for buffer room
   always_ff @(posedge clock_i) begin
      if (!nrst_i) begin
         mstate_q <= smsp_pkg::SMSP_M_IDLE;
      end else if (!is_master) begin
         mstate_q <= smsp_pkg::SMSP_M_IDLE;
      end else begin
         unique case (mstate_q)
            smsp_pkg::SMSP_M_IDLE: begin
               if (accept_wr) begin
                  mstate_q <= smsp_pkg::SMSP_M_WAIT; // R13 R12
               end
            end
            smsp_pkg::SMSP_M_WAIT: begin
               if (fifo_in_ready) begin
                  mstate_q <= smsp_pkg::SMSP_M_RUN;
               end
            end
            smsp_pkg::SMSP_M_RUN: begin
               if (m_done) begin
                  mstate_q <= smsp_pkg::SMSP_M_IDLE;
               end
            end
            default: mstate_q <= smsp_pkg::SMSP_M_IDLE;
         endcase
      end
   end

   // bit rate divider and half period counter
   always_ff @(posedge clock_i) begin
      if (!nrst_i) begin
         div_q <= 10'h000;
         t_q <= 5'h00;
      end else if (mstate_q != smsp_pkg::SMSP_M_RUN) begin
         div_q <= 10'h000;
         t_q <= 5'h00;
      end else begin
         div_q <= tick ? 10'h000 : div_q + 10'h001;
         if (run_tick) begin
            t_q <= t_n;
         end
      end
   end

   // serial clock: idles at polarity, toggles sixteen times per byte
   always_ff @(posedge clock_i) begin
      if (!nrst_i) begin
         sck_q <= 1'b0;
      end else if (run_tick && (t_n <= smsp_pkg::LAST_HALF)) begin
         sck_q <= ~sck_q; // R2
      end else if (mstate_q != smsp_pkg::SMSP_M_RUN) begin
         sck_q <= cpol; // R15
      end
   end

   // transmit shift: loaded only by an accepted write, never read back
   always_ff @(posedge clock_i) begin
      if (!nrst_i) begin
         shift_register_q <= smsp_pkg::DATA_RST;
         sdo_q <= 1'b0;
      end else if (accept_wr) begin
         shift_register_q <= buf_wdata_i; // R11
         sdo_q <= buf_wdata_i[7]; // R17
      end else if (m_change || s_change) begin
         shift_register_q <= {shift_register_q[6:0], 1'b0}; // R5
         sdo_q <= shift_register_q[6];
      end
   end

   // receive shift, msb first; a master keeps sampling sdi whatever sdo does
   assign rx_next = {rx_shift_q[6:0], sdi_s2_q};
   always_ff @(posedge clock_i) begin
      if (!nrst_i) begin
         rx_shift_q <= smsp_pkg::DATA_RST;
         rx_cnt_q <= 4'h0;
      end else if (!s_active && !is_master) begin
         rx_cnt_q <= 4'h0; // R20
      end else if (accept_wr && is_master) begin
         rx_cnt_q <= 4'h0;
      end else if (m_sample || s_sample) begin
         rx_shift_q <= rx_next; // R5 R14
         rx_cnt_q <= s_last ? 4'h0 : rx_cnt_q + 4'h1;
      end
   end

   // finished bytes enter the two-entry buffer; the last sample may land now
   assign fifo_in_valid = m_done || s_last;
   assign fifo_in_data = (m_done && !m_sample) ? rx_shift_q : rx_next;

   smsp_fifo #(
      .WIDTH(smsp_pkg::DATA_W),
      .DEPTH(smsp_pkg::RX_FIFO_DEPTH)
   ) u_rx_fifo (
      .clock_i(clock_i),
      .nrst_i(nrst_i),
      .in_valid_i(fifo_in_valid),
      .in_ready_o(fifo_in_ready),
      .in_data_i(fifo_in_data),
      .out_valid_o(fifo_out_valid),
      .out_ready_i(fifo_out_ready),
      .out_data_o(fifo_out_data)
   );

   // the buffer refills when empty or being read in this cycle
   assign fifo_out_ready = !bf_q || buf_rd_i;
   assign load_buf = fifo_out_valid && fifo_out_ready;

   // data buffer and full flag; a refill wins over the read clear
   always_ff @(posedge clock_i) begin
      if (!nrst_i) begin
         data_buffer_q <= smsp_pkg::DATA_RST;
         bf_q <= 1'b0;
      end else if (load_buf) begin
         data_buffer_q <= fifo_out_data; // R6 R7
         bf_q <= 1'b1;
      end else if (buf_rd_i) begin
         bf_q <= 1'b0; // R10
      end
   end

   // interrupt flag: set on every byte delivered, set wins over clear
   always_ff @(posedge clock_i) begin
      if (!nrst_i) begin
         int_q <= 1'b0;
      end else if (load_buf) begin
         int_q <= 1'b1; // R6
      end else if (int_clr_i) begin
         int_q <= 1'b0;
      end
   end

   // write collision: the data written while busy is simply dropped
   always_ff @(posedge clock_i) begin
      if (!nrst_i) begin
         write_collision_flag_q <= 1'b0;
      end else if (buf_wr_i && en && busy) begin
         write_collision_flag_q <= 1'b1; // R8
      end else if (write_collision_flag_clr_i) begin
         write_collision_flag_q <= 1'b0;
      end
   end

   // a slave cannot stall the far master, so a full buffer loses the byte
   always_ff @(posedge clock_i) begin
      if (!nrst_i) begin
         ovf_q <= 1'b0;
      end else if (s_last && !fifo_in_ready) begin
         ovf_q <= 1'b1;
      end else if (ovf_clr_i) begin
         ovf_q <= 1'b0;
      end
   end

   // pin enables, low while driving; slave sdo released when deselected
   always_ff @(posedge clock_i) begin
      if (!nrst_i) begin
         sck_oe_n_q <= 1'b1;
         sdo_oe_n_q <= 1'b1;
         busy_q <= 1'b0;
      end else begin
         sck_oe_n_q <= !is_master; // R2
         sdo_oe_n_q <= !(is_master || s_active);
         busy_q <= busy;
      end
   end

   assign data_buffer_o = data_buffer_q;
   assign buffer_full_flag_o = bf_q;
   assign port_interrupt_flag_o = int_q;
   assign write_collision_flag_o = write_collision_flag_q;
   assign rx_overflow_o = ovf_q;
   assign busy_o = busy_q;
   assign sck_o = sck_q;
   assign sck_oe_n_o = sck_oe_n_q;
   assign sdo_o = sdo_q;
   assign sdo_oe_n_o = sdo_oe_n_q;

   default clocking cb @(posedge clock_i); endclocking
   default disable iff (!nrst_i);

   chk_sck_drive_role: assert property ( // R2
      ##1 (sck_oe_n_o == !$past(is_master)))
      else $error("sck enable does not follow role");
   chk_idle_polarity: assert property ( // R15
      (mstate_q == smsp_pkg::SMSP_M_IDLE) && $past(mstate_q == smsp_pkg::SMSP_M_IDLE)
         && is_master && $stable(cpol) |-> (sck_o == cpol))
      else $error("idle clock level wrong");
   chk_master_start: assert property ( // R13
      is_master && accept_wr |=> (mstate_q == smsp_pkg::SMSP_M_WAIT) ##1 busy_q)
      else $error("master write did not start a transfer");
   chk_msb_early: assert property ( // R17
      accept_wr |=> (sdo_o == $past(buf_wdata_i[7])))
      else $error("msb not presented before first edge");
   chk_fosc4_half: assert property ( // R16
      run_tick && (mode == smsp_pkg::MODE_M_DIV4) && (t_n < smsp_pkg::LAST_HALF)
         && $stable(mode) |=> !tick ##1 tick)
      else $error("fosc/4 half period is not two clocks");
   chk_write_collision_flag_set: assert property ( // R8
      buf_wr_i && en && busy |=> write_collision_flag_o
         && (shift_register_q == ($past(m_change || s_change)
         ? {$past(shift_register_q[6:0]), 1'b0} : $past(shift_register_q))))
      else $error("collision not flagged or write not dropped");
   chk_load_flags: assert property ( // R6
      load_buf |=> buffer_full_flag_o && port_interrupt_flag_o
         && (data_buffer_o == $past(fifo_out_data)))
      else $error("byte delivery flags not set");
   chk_bf_read_clear: assert property ( // R10
      buf_rd_i && !fifo_out_valid |=> !buffer_full_flag_o)
      else $error("buffer read did not clear full flag");
   chk_rx_held: assert property ( // R7
      bf_q && !buf_rd_i |=> $stable(data_buffer_o) [*1])
      else $error("held byte overwritten before read");
   chk_slave_deselect: assert property ( // R20
      is_slave && ss_used && ss_s2_q |=> (rx_cnt_q == 4'h0))
      else $error("slave shifted while deselected");
   chk_master_byte_len: assert property ( // R5
      m_done |-> (rx_cnt_q == 4'h7) || (rx_cnt_q == 4'h8 && !m_sample))
      else $error("master byte not eight samples");

   cov_master_byte: cover property (m_done ##[1:4] load_buf);
   cov_slave_byte: cover property (s_last && fifo_in_ready);
   cov_collision: cover property ($rose(write_collision_flag_o));
   cov_overflow: cover property ($rose(rx_overflow_o));
endmodule // smsp_port

// [tb/smsp_far_slave.sv]
// far spi slave model answering the port in master role, idle clock low
`timescale 1ns/1ns
module smsp_far_slave (
   input wire logic clock_i,
   input wire logic load_i,
   input wire logic [7:0] tx_i,
   input wire logic sck_i,
   input wire logic sdo_i,
   output logic sdi_o,
   output logic [7:0] rx_o
);
   logic [7:0] sh_q;
   logic [3:0] n_q;
   logic sck_q;
   initial begin
      sdi_o = 1'b0;
      rx_o = 8'h00;
      sh_q = 8'h00;
      n_q = 4'h8;
      sck_q = 1'b0;
   end
   // edges seen through the system clock; sample on rise, shift on fall
   always @(posedge clock_i) begin
      sck_q <= sck_i;
      if (load_i) begin
         sh_q <= tx_i;
         sdi_o <= tx_i[7];
         n_q <= 4'h0;
      end else if (sck_i && !sck_q) begin
         rx_o <= {rx_o[6:0], sdo_i};
         n_q <= n_q + 4'h1;
      end else if (!sck_i && sck_q) begin
         sh_q <= {sh_q[6:0], 1'b0};
         // once the byte is over the line is let go: show a changing level
         sdi_o <= (n_q == 4'h8) ? ~sdi_o : sh_q[6];
      end
   end
endmodule // smsp_far_slave

// [tb/tb_top.sv]
// self-checking bench for the spi serial port
`timescale 1ns/1ns
module tb_top;
   localparam int RLD = 2;
   logic clock_i, nrst_i, tick, wr, rd, iclr, wclr, oclr;
   logic tsck, tsdi, tss, slv, pld;
   logic [5:0] ctl;
   logic [1:0] sts;
   logic [7:0] wd, ptx, dbuf, prx;
   logic bf, ifl, write_collision_flag, ovf, busy, sck, sckoe, sdo, sdooe, psdi;
   wire sdi = slv ? tsdi : psdi;
   int fail_count, comparisons, tcnt;
   smsp_port i_dut (.clock_i(clock_i), .nrst_i(nrst_i), .port_control_one_i(ctl),
      .port_status_reg_i(sts), .rate_reload_value_i(8'(RLD)), .timer2_tick_i(tick),
      .buf_wr_i(wr), .buf_wdata_i(wd), .buf_rd_i(rd), .int_clr_i(iclr),
      .write_collision_flag_clr_i(wclr), .ovf_clr_i(oclr), .data_buffer_o(dbuf),
      .buffer_full_flag_o(bf), .port_interrupt_flag_o(ifl),
      .write_collision_flag_o(write_collision_flag), .rx_overflow_o(ovf), .busy_o(busy),
      .sck_i(tsck), .sck_o(sck), .sck_oe_n_o(sckoe), .sdi_i(sdi), .sdo_o(sdo),
      .sdo_oe_n_o(sdooe), .ss_n_i(tss));
   smsp_far_slave i_far (.clock_i(clock_i), .load_i(pld), .tx_i(ptx), .sck_i(sck),
      .sdo_i(sdo), .sdi_o(psdi), .rx_o(prx));
   // free running clock and a timer tick every six cycles
   always #5 clock_i = ~clock_i;
   always @(negedge clock_i) begin
      tcnt <= (tcnt == 5) ? 0 : tcnt + 1;
      tick <= (tcnt == 5);
   end
   task automatic chk1(input logic g, input logic e, input string m);
      comparisons++;
      if (g !== e) begin
         fail_count++;
         $display("ERROR at %0t: %s got %b exp %b", $time, m, g, e);
      end
   endtask
   task automatic chk8(input logic [7:0] g, input logic [7:0] e, input string m);
      comparisons++;
      if (g !== e) begin
         fail_count++;
         $display("ERROR at %0t: %s got %h exp %h", $time, m, g, e);
      end
   endtask
   task automatic chkn(input int g, input int e, input string m);
      comparisons++;
      if (g != e) begin
         fail_count++;
         $display("ERROR at %0t: %s got %0d exp %0d", $time, m, g, e);
      end
   endtask
   task automatic cyc(input int n);
      repeat (n) @(negedge clock_i);
   endtask
   task automatic pw(input logic [7:0] d);
      wd = d;
      wr = 1'b1;
      cyc(1);
      wr = 1'b0;
   endtask
   task automatic prd();
      rd = 1'b1;
      cyc(1);
      rd = 1'b0;
   endtask
   task automatic pld_far(input logic [7:0] d);
      ptx = d;
      pld = 1'b1;
      cyc(1);
      pld = 1'b0;
   endtask
   // bounded wait on busy (k=0) or buffer full (k=1)
   task automatic wt(input int k, input logic v);
      int i;
      i = 0;
      while (((k == 0) ? busy : bf) !== v && i < 3000) begin
         cyc(1);
         i++;
      end
      if (i == 3000) begin
         fail_count++;
         $display("ERROR at %0t: wait timed out", $time);
      end
   endtask
   // setup changes only while the port is disabled
   task automatic cfg(input logic [3:0] m, input logic p, input logic [1:0] s);
      ctl[5] = 1'b0;
      cyc(1);
      ctl = {1'b0, p, m};
      sts = s;
      cyc(1);
      ctl[5] = 1'b1;
      cyc(3);
   endtask
   task automatic t_master();
      slv = 1'b0;
      cfg(smsp_pkg::MODE_M_DIV16, 1'b0, 2'b01);
      chk1(sckoe, 1'b0, "master drives sck");
      pld_far(8'h3C);
      pw(8'hA5);
      wt(0, 1'b1);
      pw(8'h11);
      cyc(1);
      chk1(write_collision_flag, 1'b1, "collision flag");
      wt(1, 1'b1);
      chk8(dbuf, 8'h3C, "received byte");
      chk1(ifl, 1'b1, "interrupt flag");
      chk8(prx, 8'hA5, "byte at far end");
      pw(8'h22);
      cyc(2);
      chk1(busy, 1'b0, "write refused while flagged");
      wclr = 1'b1;
      cyc(1);
      wclr = 1'b0;
      chk1(write_collision_flag, 1'b0, "collision cleared");
      pld_far(8'h96);
      pw(8'h5A);
      wt(0, 1'b1);
      wt(0, 1'b0);
      cyc(6);
      chk8(dbuf, 8'h3C, "first byte held");
      chk8(prx, 8'h5A, "second byte at far end");
      prd();
      cyc(3);
      chk8(dbuf, 8'h96, "second byte after read");
      chk1(bf, 1'b1, "full after refill");
      prd();
      cyc(3);
      chk1(bf, 1'b0, "read clears full");
      iclr = 1'b1;
      cyc(1);
      iclr = 1'b0;
      chk1(ifl, 1'b0, "interrupt cleared");
      $display("test master done");
   endtask
   // both clock edge settings; with the edge bit clear only mid sampling catches bit 7
   task automatic t_phase(input logic [1:0] s, input logic [7:0] a, input logic [7:0] b);
      cfg(smsp_pkg::MODE_M_DIV16, 1'b0, s);
      pld_far(a);
      pw(b);
      wt(1, 1'b1);
      chk8(dbuf, a, "phase received byte");
      chk8(prx, b, "phase sent byte");
      prd();
      cyc(2);
      $display("test phase %b done", s);
   endtask
   // measures one half period of the master clock in system cycles
   task automatic t_rate(input logic [3:0] m, input logic p, input int h);
      int n;
      logic s;
      cfg(m, p, 2'b01);
      chk1(sck, p, "idle clock level");
      pw(8'h00);
      s = sck;
      n = 0;
      while (sck === s && n < 300) begin
         cyc(1);
         n++;
      end
      s = sck;
      n = 0;
      while (sck === s && n < 300) begin
         cyc(1);
         n++;
      end
      chkn(n, h, "half bit period");
      wt(1, 1'b1);
      prd();
      cyc(2);
      $display("test rate mode %h done", m);
   endtask
   // the bench plays the far master: sck half period of four cycles
   task automatic t_slave();
      slv = 1'b1;
      tss = 1'b0;
      cfg(smsp_pkg::MODE_S_SSEN, 1'b0, 2'b01);
      chk1(sckoe, 1'b1, "slave takes sck");
      pw(8'hC3);
      cyc(3);
      // four unread bytes: buffer plus two entries hold three, the fourth is lost
      for (int b = 0; b < 4; b++) begin
         for (int i = 7; i >= 0; i--) begin
            tsdi = 1'(8'h69 >> i);
            cyc(4);
            if (b == 0) begin
               chk1(sdo, 1'(8'hC3 >> i), "slave output bit");
            end
            tsck = 1'b1;
            cyc(4);
            tsck = 1'b0;
         end
      end
      wt(1, 1'b1);
      chk8(dbuf, 8'h69, "slave received byte");
      chk1(ovf, 1'b1, "fourth byte overflows");
      prd();
      tss = 1'b1;
      cyc(5);
      chk1(sdooe, 1'b1, "output let go when deselected");
      oclr = 1'b1;
      cyc(1);
      oclr = 1'b0;
      chk1(ovf, 1'b0, "no overflow");
      $display("test slave done");
   endtask
   task automatic finish_test();
      $display("checks %0d mismatches %0d", comparisons, fail_count);
      if (fail_count == 0 && comparisons > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask
   initial begin
      #300000;
      fail_count++;
      $display("ERROR at %0t: watchdog expired", $time);
      finish_test();
   end
   initial begin
      {clock_i, nrst_i, tick, wr, rd, iclr, wclr, oclr, tsck, tsdi, slv, pld} = '0;
      tss = 1'b1;
      ctl = 6'h00;
      sts = 2'h0;
      wd = 8'h00;
      ptx = 8'h00;
      tcnt = 0;
      fail_count = 0;
      comparisons = 0;
      cyc(20);
      chk1(bf, 1'b0, "reset full flag");
      chk1(write_collision_flag, 1'b0, "reset collision flag");
      chk8(dbuf, 8'h00, "reset data buffer");
      chk1(sdooe, 1'b1, "reset output released");
      nrst_i = 1'b1;
      cyc(2);
      t_master();
      t_phase(2'b11, 8'hB4, 8'h4B);
      t_phase(2'b00, 8'h69, 8'h96);
      t_rate(smsp_pkg::MODE_M_DIV4, 1'b0, smsp_pkg::HALF_DIV4);
      t_rate(smsp_pkg::MODE_M_DIV16, 1'b1, smsp_pkg::HALF_DIV16);
      t_rate(smsp_pkg::MODE_M_DIV64, 1'b0, smsp_pkg::HALF_DIV64);
      t_rate(smsp_pkg::MODE_M_TMR2, 1'b0, 6);
      t_rate(smsp_pkg::MODE_M_RELOAD, 1'b0, 2 * (RLD + 1));
      t_slave();
      finish_test();
   end
endmodule // tb_top
